/* logic/aic_consts.svh */
// Constants for the analog input channel readout: offsets, codes, timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef AIC_CONSTS_SVH
`define AIC_CONSTS_SVH
// Timing
`define AIC_CLK_NS 32'h0000_0014
`define AIC_TICK_MS 32'h0000_000a
`define AIC_NS_PER_MS 32'h000f_4240
`define AIC_INIT_CYC 32'h0000_0010
// Conversion
`define AIC_FULL_SCALE 64'sh0fff
`define AIC_OHM_LSB 64'sh0019
`define AIC_LN2_Q 64'sh00b1
`define AIC_Q_BITS 8
`define AIC_RTD_MAX_POS 64'shc350
`define AIC_RTD_MAX_NEG 64'sh7fff
`define AIC_PCT 64'sh0064
`define AIC_VOLT_TOL_MAX 64'sh0003
`define AIC_F_MUL 64'sh0009
`define AIC_F_DIV 64'sh0005
`define AIC_F_OFS 64'sh0020
`define AIC_RES_DIV 64'sh000a
`define AIC_SAT_HI 64'shffff
`define AIC_SAT_LO (-64'sh8000)
// Register offsets (byte addresses)
`define AIC_REG_CTRL 8'h00
`define AIC_REG_REFRESH 8'h04
`define AIC_REG_FILTER 8'h08
`define AIC_REG_TOL 8'h0c
`define AIC_REG_RANGE 8'h10
`define AIC_REG_GSTAT 8'h14
`define AIC_REG_THERM 8'h20
`define AIC_REG_CHCFG 8'h40
`define AIC_REG_CHDATA 8'h80
`define AIC_THERM_SPAN 9'h020
`define AIC_CHDATA_SPAN 9'h080
// Channel config fields
`define AIC_CFG_VOLT 3
`define AIC_CFG_RTD 4
`define AIC_CFG_EN 5
`define AIC_DT_MAX 3'h4
// Periodic status codes
`define AIC_SC_NORMAL 16'h0000
`define AIC_SC_FIRST 16'h0001
`define AIC_SC_INIT 16'h0002
`define AIC_SC_PARAM 16'h0003
`define AIC_SC_SUPPLY 16'h0004
`define AIC_SC_OVER 16'h0005
`define AIC_SC_UNDER 16'h0006
// Bus responses
`define AIC_RESP_OK 2'h0
`define AIC_RESP_ERR 2'h2
`endif

/* logic/aic_pkg.sv */
// Types shared by the readout top and its converter.
// Assumes nothing beyond a SystemVerilog compile.
package aic_pkg;
   typedef enum logic [2:0] {
      aic_dt_binary, aic_dt_optional, aic_dt_celsius, aic_dt_fahrenheit, aic_dt_resistance
   } aic_dtype_t;
   typedef enum logic {aic_st_init, aic_st_active} aic_state_t;
endpackage

/* logic/aic_conv_if.sv */
// One channel's settings into the converter and its result back.
// Assumes the readout top drives the user side.
`timescale 1ns/1ps
interface aic_conv_if;
   import aic_pkg::*;
   logic signed [13:0] raw;
   aic_dtype_t dtype;
   logic volt;
   logic rtd100;
   logic signed [15:0] rmin;
   logic signed [15:0] rmax;
   logic signed [15:0] t0;
   logic [15:0] r0;
   logic [15:0] beta;
   logic [7:0] tol_max;
   logic [7:0] tol_min;
   logic [15:0] value;
   logic over;
   logic under;
   modport conv (input raw, dtype, volt, rtd100, rmin, rmax, t0, r0, beta, tol_max,
      tol_min, output value, over, under);
   modport user (output raw, dtype, volt, rtd100, rmin, rmax, t0, r0, beta, tol_max,
      tol_min, input value, over, under);
endinterface

/* logic/aic_conv.sv */
// Combinational scaling of one channel sample, with range checks.
// Assumes a signed sample where 0..4095 is the nominal full scale.
`timescale 1ns/1ps
`include "aic_consts.svh"
module aic_conv
   import aic_pkg::*;
(
   aic_conv_if.conv c
);
   // Log2 in fixed point, integer part above the fraction
   function automatic logic [12:0] aic_log2q(input logic [23:0] x);
      logic [4:0] msb;
      logic [23:0] nrm;
      msb = 5'h00;
      for (int i = 0; i < 24; i++) begin
         if (x[i]) msb = 5'(i);
      end
      nrm = x << (5'h17 - msb);
      return {msb, nrm[22:15]};
   endfunction

   // Results above 32767 read as unsigned, as the hundredfold ranges need
   function automatic logic [15:0] aic_sat(input longint v);
      if (v > `AIC_SAT_HI) return 16'hffff;
      if (v < `AIC_SAT_LO) return 16'h8000;
      return v[15:0];
   endfunction

   longint fs, tmax, tmin, clip, lo, hi, ohm, lnq, num, den, v;

   // Tolerance band, clip, then type-specific scaling
   always_comb begin
      fs = `AIC_FULL_SCALE;
      tmax = longint'(c.tol_max);
      if (c.volt && tmax > `AIC_VOLT_TOL_MAX) tmax = `AIC_VOLT_TOL_MAX;
      tmin = c.volt ? 64'sh0 : longint'(c.tol_min);
      c.over = longint'(c.raw) > fs + fs * tmax / `AIC_PCT;
      c.under = longint'(c.raw) < -(fs * tmin / `AIC_PCT);
      clip = (c.raw < 0) ? 64'sh0 : (longint'(c.raw) > fs) ? fs : longint'(c.raw);
      lo = longint'(c.rmin);
      // Only the minimum counts in hundredfold thermometer mode
      if (c.rtd100) begin
         hi = (c.rmin == 16'sh0000) ? `AIC_RTD_MAX_POS : `AIC_RTD_MAX_NEG;
      end else begin
         hi = longint'(c.rmax);
      end
      ohm = clip * `AIC_OHM_LSB;
      // Natural log from log2; coarse but cheap, no table needed
      lnq = ((longint'(aic_log2q(ohm[23:0])) - longint'(aic_log2q({8'h00, c.r0})))
         * `AIC_LN2_Q) >>> `AIC_Q_BITS;
      num = (longint'(c.beta) * longint'(c.t0)) <<< `AIC_Q_BITS;
      den = (longint'(c.beta) <<< `AIC_Q_BITS) + longint'(c.t0) * lnq;
      case (c.dtype)
         aic_dt_binary: v = clip;
         aic_dt_optional: v = lo + (hi - lo) * clip / fs;
         aic_dt_celsius, aic_dt_fahrenheit: begin
            if (c.rtd100) begin
               v = lo + (hi - lo) * clip / fs;
            end else begin
               v = (den == 0) ? 64'sh0 : num / den;
               if (c.dtype == aic_dt_fahrenheit) v = v * `AIC_F_MUL / `AIC_F_DIV + `AIC_F_OFS;
            end
         end
         aic_dt_resistance: v = ohm / `AIC_RES_DIV;
         default: v = 64'sh0;
      endcase
      c.value = aic_sat(v);
   end
endmodule

/* logic/aic_readout.sv */
// Analog input channel readout: AXI4-Lite registers, refresh timing, status.
// Assumes samples synchronous to aclk; run state and scan end come from the CPU.
// Contract
// - Optional range scales linearly between min and max
// - Hundredfold thermometer mode derives maximum from minimum
// - Filter accepts 0..255; larger is parameter error
// - Thermistor parameters shared per four channels
// - R0 and B unsigned, T0 signed 16-bit
// - NEGATIVE_COEFFICIENT_THERMISTOR result uses B, T0, log ratio
// - Periodic data lands in fixed per-channel register
// - Periodic updates continue while running or stopped
// - Running: scan end after 10 ms; stopped: 10 ms
// - On-demand updates only on refresh instruction
// - Unused on-demand channel returns undefined data
// - Periodic status lands beside its data register
// - Status codes zero through six as listed
// - On-demand bits: init, parameter, supply error
// - Bits: over max, under min; rest zero
// - Over/under thresholds are percent of full scale
// - One tolerance setting serves every channel
// - Voltage max tolerance clamps to 3%, min 0
// - Binary type yields 0 to 4095
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "aic_consts.svh"
module aic_readout
   import aic_pkg::*;
#(
   parameter int NCH = 8,
   parameter int unsigned TICK_CYCLES = `AIC_TICK_MS * `AIC_NS_PER_MS / `AIC_CLK_NS,
   parameter int unsigned INIT_CYCLES = `AIC_INIT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0][13:0] raw_sample,
   input wire logic supply_fail,
   input wire logic cpu_running,
   input wire logic scan_end
);
   if (NCH < 1 || NCH > 8) $error("aic_readout: NCH must be 1..8");
   if (TICK_CYCLES < 2 || INIT_CYCLES < 1) $error("aic_readout: counts too small");

   typedef struct packed {
      aic_state_t st;
      logic [31:0] init_cnt;
      logic [31:0] tick_cnt;
      logic tick_done;
      logic on_demand;
      logic refresh_req;
      logic [7:0] filter;
      logic filt_err;
      logic [7:0] tol_max;
      logic [7:0] tol_min;
      logic [15:0] rmin;
      logic [15:0] rmax;
      logic [1:0][15:0] r0;
      logic [1:0][15:0] t0;
      logic [1:0][15:0] beta;
      logic [NCH-1:0][5:0] chcfg;
      logic [NCH-1:0][15:0] data;
      logic [NCH-1:0][15:0] code;
      logic [NCH-1:0][15:0] flags;
      logic [NCH-1:0] first;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } aic_regs_t;

   aic_regs_t r;
   aic_regs_t next_r;
   logic upd;
   logic [NCH-1:0][15:0] conv_val;
   logic [NCH-1:0] conv_over;
   logic [NCH-1:0] conv_under;
   logic [NCH-1:0] par_err;

   // Address window test, shared by read and write decode
   function automatic logic aic_in(input logic [7:0] a, input logic [7:0] base,
      input logic [8:0] span);
      return ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < {1'b0, base} + span);
   endfunction

   // Byte-lane merge of a write into the old word
   function automatic logic [31:0] aic_merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) m[b*8 +: 8] = wd[b*8 +: 8];
      end
      return m;
   endfunction

   // Status priority: init, then parameter, first pass, supply, range
   function automatic logic [15:0] aic_code(input logic en, input logic par, input logic ini,
      input logic fst, input logic sup, input logic ov, input logic un);
      if (ini) return `AIC_SC_INIT;
      if (par || !en) return `AIC_SC_PARAM;
      if (fst) return `AIC_SC_FIRST;
      if (sup) return `AIC_SC_SUPPLY;
      if (ov) return `AIC_SC_OVER;
      if (un) return `AIC_SC_UNDER;
      return `AIC_SC_NORMAL;
   endfunction

   // One converter per channel; thermistor set picked by channel group
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      aic_conv_if cif();
      assign cif.raw = raw_sample[g];
      assign cif.dtype = aic_dtype_t'(r.chcfg[g][2:0]);
      assign cif.volt = r.chcfg[g][`AIC_CFG_VOLT];
      assign cif.rtd100 = r.chcfg[g][`AIC_CFG_RTD];
      assign cif.rmin = r.rmin;
      assign cif.rmax = r.rmax;
      assign cif.r0 = r.r0[g / 4];
      assign cif.t0 = r.t0[g / 4];
      assign cif.beta = r.beta[g / 4];
      assign cif.tol_max = r.tol_max;
      assign cif.tol_min = r.tol_min;
      aic_conv u_conv (
         .c(cif)
      );
      assign conv_val[g] = cif.value;
      assign conv_over[g] = cif.over;
      assign conv_under[g] = cif.under;
      assign par_err[g] = r.filt_err || (r.chcfg[g][2:0] > `AIC_DT_MAX);
   end

   // Refresh moment: periodic waits for tick and scan end when running
   assign upd = r.on_demand ? r.refresh_req
      : (r.tick_done && (!cpu_running || scan_end));

   // Bus handshakes; one write and one read in flight
   assign s_axi_awready = !r.aw_got && !r.bvalid;
   assign s_axi_wready = !r.w_got && !r.bvalid;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   // All next-state logic
   always_comb begin
      logic [31:0] wd;
      logic [7:0] a;
      logic [2:0] ci;
      wd = 32'h0000_0000;
      a = r.aw_addr;
      ci = 3'h0;
      next_r = r;
      next_r.refresh_req = 1'b0;
      // Init countdown after reset or a configuration change
      if (r.st == aic_st_init) begin
         if (r.init_cnt == 32'(INIT_CYCLES - 1)) begin
            next_r.st = aic_st_active;
         end else begin
            next_r.init_cnt = r.init_cnt + 32'h0000_0001;
         end
      end
      // Ten-millisecond tick; held done until a periodic update takes it
      if (r.tick_cnt == 32'(TICK_CYCLES - 1)) begin
         next_r.tick_done = 1'b1;
      end else begin
         next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
      end
      if (upd && !r.on_demand) begin
         next_r.tick_cnt = 32'h0000_0000;
         next_r.tick_done = 1'b0;
      end
      // Data and status from one conversion in the same edge; unused channels
      // are written too, so their contents are whatever the input gave
      if (upd) begin
         for (int ch = 0; ch < NCH; ch++) begin
            next_r.data[ch] = conv_val[ch];
            next_r.code[ch] = aic_code(r.chcfg[ch][`AIC_CFG_EN], par_err[ch],
               r.st == aic_st_init, r.first[ch], supply_fail, conv_over[ch], conv_under[ch]);
            next_r.flags[ch] = {11'h000, conv_under[ch], conv_over[ch], supply_fail,
               par_err[ch] || !r.chcfg[ch][`AIC_CFG_EN], r.st == aic_st_init};
            next_r.first[ch] = 1'b0;
         end
      end
      // Write channels captured independently
      if (s_axi_awvalid && s_axi_awready) begin
         next_r.aw_got = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
      // Register write once both halves are in
      if (r.aw_got && r.w_got) begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = `AIC_RESP_OK;
         next_r.st = aic_st_init;
         next_r.init_cnt = 32'h0000_0000;
         if (a == `AIC_REG_CTRL) begin
            wd = aic_merge({31'h0, r.on_demand}, r.wdata, r.wstrb);
            next_r.on_demand = wd[0];
         end else if (a == `AIC_REG_REFRESH) begin
            wd = aic_merge(32'h0000_0000, r.wdata, r.wstrb);
            next_r.refresh_req = wd[0];
            next_r.st = (r.init_cnt == 32'(INIT_CYCLES - 1)) ? aic_st_active : r.st;
            next_r.init_cnt = next_r.st == aic_st_init ? r.init_cnt + 32'h0000_0001 : r.init_cnt;
         end else if (a == `AIC_REG_FILTER) begin
            wd = aic_merge({24'h0, r.filter}, r.wdata, r.wstrb);
            // Out-of-range value kept out of the register, flagged instead
            if (|wd[31:8]) begin
               next_r.filt_err = 1'b1;
            end else begin
               next_r.filter = wd[7:0];
               next_r.filt_err = 1'b0;
            end
         end else if (a == `AIC_REG_TOL) begin
            wd = aic_merge({16'h0, r.tol_min, r.tol_max}, r.wdata, r.wstrb);
            next_r.tol_max = wd[7:0];
            next_r.tol_min = wd[15:8];
         end else if (a == `AIC_REG_RANGE) begin
            wd = aic_merge({r.rmax, r.rmin}, r.wdata, r.wstrb);
            next_r.rmin = wd[15:0];
            next_r.rmax = wd[31:16];
         end else if (aic_in(a, `AIC_REG_THERM, `AIC_THERM_SPAN) && a[3:2] != 2'h3) begin
            if (a[3:2] == 2'h0) begin
               wd = aic_merge({16'h0, r.r0[a[4]]}, r.wdata, r.wstrb);
               next_r.r0[a[4]] = wd[15:0];
            end else if (a[3:2] == 2'h1) begin
               wd = aic_merge({16'h0, r.t0[a[4]]}, r.wdata, r.wstrb);
               next_r.t0[a[4]] = wd[15:0];
            end else begin
               wd = aic_merge({16'h0, r.beta[a[4]]}, r.wdata, r.wstrb);
               next_r.beta[a[4]] = wd[15:0];
            end
         end else if (aic_in(a, `AIC_REG_CHCFG, 9'(NCH * 4))) begin
            ci = a[4:2];
            wd = aic_merge({26'h0, r.chcfg[ci]}, r.wdata, r.wstrb);
            next_r.chcfg[ci] = wd[5:0];
         end else begin
            next_r.bresp = `AIC_RESP_ERR;
            next_r.st = (r.init_cnt == 32'(INIT_CYCLES - 1)) ? aic_st_active : r.st;
            next_r.init_cnt = next_r.st == aic_st_init ? r.init_cnt + 32'h0000_0001 : r.init_cnt;
         end
      end
      // Read path, answered in the next cycle
      if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = `AIC_RESP_OK;
         next_r.rdata = 32'h0000_0000;
         a = s_axi_araddr;
         ci = a[6:4];
         if (a == `AIC_REG_CTRL) begin
            next_r.rdata = {31'h0, r.on_demand};
         end else if (a == `AIC_REG_REFRESH) begin
            next_r.rdata = 32'h0000_0000;
         end else if (a == `AIC_REG_FILTER) begin
            next_r.rdata = {24'h0, r.filter};
         end else if (a == `AIC_REG_TOL) begin
            next_r.rdata = {16'h0, r.tol_min, r.tol_max};
         end else if (a == `AIC_REG_RANGE) begin
            next_r.rdata = {r.rmax, r.rmin};
         end else if (a == `AIC_REG_GSTAT) begin
            next_r.rdata = {30'h0, r.st == aic_st_init, r.filt_err};
         end else if (aic_in(a, `AIC_REG_THERM, `AIC_THERM_SPAN)) begin
            if (a[3:2] == 2'h0) next_r.rdata = {16'h0, r.r0[a[4]]};
            else if (a[3:2] == 2'h1) next_r.rdata = {16'h0, r.t0[a[4]]};
            else if (a[3:2] == 2'h2) next_r.rdata = {16'h0, r.beta[a[4]]};
         end else if (aic_in(a, `AIC_REG_CHCFG, 9'(NCH * 4))) begin
            next_r.rdata = {26'h0, r.chcfg[a[4:2]]};
         end else if (aic_in(a, `AIC_REG_CHDATA, `AIC_CHDATA_SPAN) && 32'(ci) < NCH) begin
            if (a[3:2] == 2'h0) next_r.rdata = {16'h0, r.data[ci]};
            else if (a[3:2] == 2'h1) next_r.rdata = {16'h0, r.code[ci]};
            else if (a[3:2] == 2'h2) next_r.rdata = {16'h0, r.flags[ci]};
         end else begin
            next_r.rresp = `AIC_RESP_ERR;
         end
      end
   end

   // State register; reset lands in init with every channel on its first pass
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.st <= aic_st_init;
         r.first <= '1;
      end else begin
         r <= next_r;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_demand_only_refresh: assert property (r.on_demand && !r.refresh_req |-> !upd)
      else $error("on-demand update without refresh");
   chk_run_waits_scan: assert property (!r.on_demand && cpu_running && !scan_end |-> !upd)
      else $error("running update off scan end");
   chk_tick_before_update: assert property (!r.on_demand && upd |-> r.tick_done
      && r.tick_cnt == 32'(TICK_CYCLES - 1)) else $error("update before tick");
   chk_stop_updates: assert property (!r.on_demand && !cpu_running && r.tick_done |-> upd)
      else $error("stopped mode missed tick");
   chk_pair_write: assert property (upd |=> r.data[0] == $past(conv_val[0])
      && (r.code[0] != `AIC_SC_OVER || $past(conv_over[0])))
      else $error("data and status split");
   chk_supply_code: assert property (upd && supply_fail |=> r.code[0] != `AIC_SC_NORMAL
      && r.flags[0][2]) else $error("supply failure not reported");
   chk_init_flag: assert property (upd && r.st == aic_st_init |=> r.flags[0][0]
      && r.code[0] == `AIC_SC_INIT) else $error("init not flagged");
   chk_reserved_zero: assert property (upd |=> r.flags[0][15:5] == 11'h000)
      else $error("reserved status bits set");
   chk_binary_range: assert property (r.chcfg[0][2:0] == 3'h0 |-> conv_val[0] <= 16'h0fff)
      else $error("binary result above 4095");
   chk_filter_refuse: assert property (r.aw_got && r.w_got && r.aw_addr == `AIC_REG_FILTER
      && r.wstrb[1] && r.wdata[15:8] != 8'h00 |=> r.filt_err && $stable(r.filter))
      else $error("filter overflow accepted");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");

   cov_periodic_run: cover property (!r.on_demand && cpu_running && upd);
   cov_periodic_stop: cover property (!r.on_demand && !cpu_running && upd);
   cov_demand: cover property (r.on_demand && upd);
   cov_over_range: cover property (upd && conv_over[0]);
endmodule

/* sim/aic_sensor_model.sv */
// Behavioural analog sensor feeding every channel of the readout.
// Assumes the bench sets target samples and the supply state.
`timescale 1ns/1ps
module aic_sensor_model #(
   parameter int NCH = 8
) (
   input wire logic aclk,
   input wire logic [NCH-1:0][13:0] target,
   input wire logic fail_req,
   output logic [NCH-1:0][13:0] raw_sample,
   output logic supply_fail
);
   // Samples settle one clock late, like a real front end; raw only, no linearising
   always_ff @(posedge aclk) begin
      raw_sample <= target;
      supply_fail <= fail_req;
   end
endmodule

/* sim/tb_aic_readout.sv */
// Self-checking bench for the analog input readout over AXI4-Lite.
// Assumes short tick and init counts so refreshes come within tens of cycles.
`timescale 1ns/1ps
module tb_aic_readout;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, supply_fail;
   logic [1:0] bresp, rresp, r;
   logic [7:0][13:0] tgt = '0;
   logic [7:0][13:0] raw;
   logic fail_req = 0, cpu_running = 0, scan_end = 0;
   int n_fail = 0;
   int checks_done = 0;

   // 50 MHz clock
   always #10 aclk = ~aclk;

   aic_sensor_model #(.NCH(8)) i_sensor (.aclk(aclk), .target(tgt), .fail_req(fail_req),
      .raw_sample(raw), .supply_fail(supply_fail));
   aic_readout #(.NCH(8), .TICK_CYCLES(20), .INIT_CYCLES(2)) i_dut (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .raw_sample(raw), .supply_fail(supply_fail), .cpu_running(cpu_running),
      .scan_end(scan_end));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_fail++;
      end
   endtask
   // Each channel released on its own handshake; only the watchdog ends a wait.
   // An edge passes first, so ready is never dropped and raised in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready === 1) awvalid <= 0;
         if (wready === 1) wvalid <= 0;
      end while (bvalid !== 1);
      r = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready === 1) arvalid <= 0;
      end while (rvalid !== 1);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task automatic ex(input string nm, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(nm, e, d);
   endtask
   // Long enough for init plus two periodic refreshes
   task automatic settle();
      repeat (50) @(posedge aclk);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog, well beyond the roughly 1150 cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      conclude();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      wr(8'h40, 32'h20);
      wr(8'h50, 32'h28);
      tgt[0] <= 14'h3e8;
      tgt[4] <= 14'h7d0;
      settle();
      ex("code0", 8'h84, 32'h0);
      ex("data0", 8'h80, 32'h3e8);
      ex("data4", 8'hc0, 32'h7d0);
      ex("flag0", 8'h88, 32'h0);
      done("map");
      tgt[0] <= 14'h1388;
      settle();
      ex("over", 8'h84, 32'h5);
      ex("overf", 8'h88, 32'h8);
      ex("clip", 8'h80, 32'hfff);
      tgt[0] <= 14'h3ffb;
      settle();
      ex("under", 8'h84, 32'h6);
      ex("underf", 8'h88, 32'h10);
      done("limits");
      wr(8'h0c, 32'h0205);
      tgt[0] <= 14'h10cb;
      tgt[4] <= 14'h10cb;
      settle();
      ex("tolc", 8'h84, 32'h0);
      ex("tolv", 8'hc4, 32'h5);
      tgt[0] <= 14'h3faf;
      tgt[4] <= 14'h3fff;
      settle();
      ex("minc", 8'h84, 32'h0);
      ex("minv", 8'hc4, 32'h6);
      tgt[0] <= 14'h3fae;
      settle();
      ex("minc2", 8'h84, 32'h6);
      done("tolerance");
      wr(8'h08, 32'h100);
      tgt[0] <= 14'h064;
      settle();
      ex("fcode", 8'h84, 32'h3);
      ex("fflag", 8'h88, 32'h2);
      ex("gstat", 8'h14, 32'h1);
      wr(8'h08, 32'hff);
      settle();
      ex("fok", 8'h84, 32'h0);
      done("filter");
      wr(8'h10, 32'h03e8fc18);
      wr(8'h40, 32'h21);
      tgt[0] <= 14'hfff;
      settle();
      ex("optmax", 8'h80, 32'h3e8);
      tgt[0] <= 14'h000;
      settle();
      ex("optmin", 8'h80, 32'hfc18);
      // Celsius thermometer at hundredfold scale, minimum 0
      wr(8'h10, 32'h0);
      wr(8'h40, 32'h32);
      tgt[0] <= 14'h800;
      settle();
      ex("autmax", 8'h80, 32'h61ae);
      done("range");
      wr(8'h40, 32'h20);
      tgt[0] <= 14'h064;
      fail_req <= 1;
      settle();
      ex("sup", 8'h84, 32'h4);
      ex("supf", 8'h88, 32'h4);
      ex("nochan", 8'h94, 32'h3);
      fail_req <= 0;
      settle();
      ex("supok", 8'h84, 32'h0);
      done("supply");
      wr(8'h20, 32'hffff);
      wr(8'h24, 32'h8000);
      wr(8'h30, 32'h9c4);
      wr(8'h34, 32'h19);
      wr(8'h38, 32'hd6b);
      ex("r0", 8'h20, 32'hffff);
      ex("t0", 8'h24, 32'h8000);
      ex("grp1", 8'h30, 32'h9c4);
      // Channel 4 reads its group's R0, so the log term vanishes: result is T0
      wr(8'h50, 32'h22);
      tgt[4] <= 14'h064;
      settle();
      ex("ntc", 8'hc0, 32'h19);
      wr(8'h50, 32'h23);
      settle();
      ex("ntcf", 8'hc0, 32'h4d);
      wr(8'h2c, 32'h1);
      chk("resv", 32'h2, {30'h0, r});
      wr(8'h18, 32'h1);
      chk("unmw", 32'h2, {30'h0, r});
      rd(8'h18);
      chk("unmr", 32'h2, {30'h0, r});
      done("therm");
      cpu_running <= 1;
      tgt[0] <= 14'h12c;
      settle();
      ex("noscan", 8'h80, 32'h64);
      scan_end <= 1;
      @(posedge aclk);
      scan_end <= 0;
      repeat (3) @(posedge aclk);
      ex("scan", 8'h80, 32'h12c);
      done("running");
      cpu_running <= 0;
      wr(8'h00, 32'h1);
      tgt[0] <= 14'h2bc;
      settle();
      ex("hold", 8'h80, 32'h12c);
      fail_req <= 1;
      wr(8'h04, 32'h1);
      repeat (5) @(posedge aclk);
      ex("refr", 8'h80, 32'h2bc);
      ex("dflag", 8'h88, 32'h4);
      ex("dcode", 8'h84, 32'h4);
      done("demand");
      // Mid-run reset; the first refresh after it lands near cycle 21
      fail_req <= 0;
      aresetn <= 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      wr(8'h40, 32'h20);
      repeat (20) @(posedge aclk);
      ex("fresh", 8'h84, 32'h1);
      settle();
      ex("settled", 8'h84, 32'h0);
      done("reset");
      conclude();
   end
endmodule
